// >>> rtl/wkg_params.svh
// constants for the wake enable gating block
// assumes 32-bit axi4-lite register bus, byte addressing
`ifndef WKG_PARAMS_SVH
`define WKG_PARAMS_SVH
// printed offsets 0c/0d are not multiples of four: they are indices
`define WKG_IDX_EN3 4'hc
`define WKG_IDX_EN4 4'hd
`define WKG_IDX_STS3 4'h4
`define WKG_IDX_STS4 4'h5
`define WKG_IDX_MASTER 4'h6
`define WKG_IDX_W 4
`define WKG_EN_RESET 8'h00
`define WKG_GRP_BIT 3
`define WKG_RESP_OKAY 2'b00
`define WKG_RESP_SLVERR 2'b10
`endif

// >>> rtl/wkg_pkg.sv
// types for the wake enable gating block
// assumes wkg_params.svh is on the include path
package wkg_pkg;
  typedef enum logic [0:0] {WKG_W_IDLE, WKG_W_RESP} wkg_wstate_t;
  typedef enum logic [0:0] {WKG_R_IDLE, WKG_R_RESP} wkg_rstate_t;
endpackage : wkg_pkg

// >>> rtl/wkg_gate.sv
// wake output combiner
// assumes enable and status words are registered by the caller
module wkg_gate
  import wkg_pkg::*;
(
  input wire logic [7:0] en3,
  input wire logic [7:0] en4,
  input wire logic [7:0] sts3,
  input wire logic [7:0] sts4,
  input wire logic master_en,
  output logic wake_n
);
  // --------------------------------
  // and per source, or, master gate
  // --------------------------------
  always_comb
  begin
    wake_n = ~(master_en & (|((en3 & sts3) | (en4 & sts4))));
  end
endmodule : wkg_gate

// >>> rtl/wkg_top.sv
// wake enable gating with axi4-lite registers
// assumes sources give one-cycle or level events synchronous to mclk
//
// Local design decision: the AXI4-Lite slave port.
`include "wkg_params.svh"

// Contract
// - wake asserted only when source enable, status and master enable all set
// - disabled source still records status but never asserts wake
// - enables survive other resets; cleared to zero only by standby power-on reset
// - enable three maps pins 20-22, grouped irq, pins 24-27
// - enable three bit three gates the grouped interrupt source
// - enable four maps pins 30-33, 41, 43, 60, 61
// - both enables eight bits, read-write, one bit per source
// - status set on any wake event regardless of enables
module wkg_top
  import wkg_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic standby_supply_power_on_reset,
  input wire logic gpin_20,
  input wire logic gpin_21,
  input wire logic gpin_22,
  input wire logic grouped_irq,
  input wire logic gpin_24,
  input wire logic gpin_25,
  input wire logic gpin_26,
  input wire logic gpin_27,
  input wire logic gpin_30,
  input wire logic gpin_31,
  input wire logic gpin_32,
  input wire logic gpin_33,
  input wire logic gpin_41,
  input wire logic gpin_43,
  input wire logic gpin_60,
  input wire logic gpin_61,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wake_request_out_n
);
  // --------------------------------
  // state
  // --------------------------------
  typedef struct packed {
    logic [7:0] en3;
    logic [7:0] en4;
    logic [7:0] sts3;
    logic [7:0] sts4;
    logic wake_master_enable;
    wkg_wstate_t wst;
    logic aw_got;
    logic w_got;
    logic [`WKG_IDX_W-1:0] widx;
    logic [31:0] wdata;
    logic wstrb0;
    logic [1:0] bresp;
    wkg_rstate_t rst_s;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wkg_state_t;

  wkg_state_t st_reg;
  wkg_state_t st_next;
  logic [7:0] ev3;
  logic [7:0] ev4;
  logic wake_n;

  // word index from byte address; low two bits ignored
  function automatic logic [`WKG_IDX_W-1:0] wkg_idx(input logic [31:0] a);
    wkg_idx = a[`WKG_IDX_W+1:2];
  endfunction : wkg_idx

  function automatic logic wkg_hit(input logic [31:0] a);
    logic [`WKG_IDX_W-1:0] i;
    i = wkg_idx(a);
    wkg_hit = (a[31:`WKG_IDX_W+2] == '0) &&
      (i == `WKG_IDX_EN3 || i == `WKG_IDX_EN4 || i == `WKG_IDX_STS3 ||
       i == `WKG_IDX_STS4 || i == `WKG_IDX_MASTER);
  endfunction : wkg_hit

  // --------------------------------
  // source bit maps
  // --------------------------------
  always_comb
  begin
    ev3 = {gpin_27, gpin_26, gpin_25, gpin_24, grouped_irq,
           gpin_22, gpin_21, gpin_20};
    ev4 = {gpin_61, gpin_60, gpin_43, gpin_41, gpin_33,
           gpin_32, gpin_31, gpin_30};
  end

  // --------------------------------
  // next state
  // --------------------------------
  always_comb
  begin
    st_next = st_reg;
    // write-one-to-clear, but a new event in the same cycle wins
    // an address answered with slverr must not touch any register
    if (st_reg.wst == WKG_W_IDLE && st_reg.aw_got && st_reg.w_got && st_reg.wstrb0 &&
        st_reg.bresp == `WKG_RESP_OKAY)
    begin
      if (st_reg.widx == `WKG_IDX_STS3)
        st_next.sts3 = st_reg.sts3 & ~st_reg.wdata[7:0];
      if (st_reg.widx == `WKG_IDX_STS4)
        st_next.sts4 = st_reg.sts4 & ~st_reg.wdata[7:0];
    end
    st_next.sts3 = st_next.sts3 | ev3;
    st_next.sts4 = st_next.sts4 | ev4;
    case (st_reg.wst)
      WKG_W_IDLE:
      begin
        if (s_axi_awvalid && !st_reg.aw_got)
        begin
          st_next.aw_got = 1'b1;
          st_next.widx = wkg_idx(s_axi_awaddr);
          st_next.bresp = wkg_hit(s_axi_awaddr) ? `WKG_RESP_OKAY : `WKG_RESP_SLVERR;
        end
        if (s_axi_wvalid && !st_reg.w_got)
        begin
          st_next.w_got = 1'b1;
          st_next.wdata = s_axi_wdata;
          st_next.wstrb0 = s_axi_wstrb[0];
        end
        if (st_reg.aw_got && st_reg.w_got)
        begin
          if (st_reg.wstrb0 && st_reg.bresp == `WKG_RESP_OKAY)
          begin
            case (st_reg.widx)
              `WKG_IDX_EN3: st_next.en3 = st_reg.wdata[7:0];
              `WKG_IDX_EN4: st_next.en4 = st_reg.wdata[7:0];
              `WKG_IDX_MASTER: st_next.wake_master_enable = st_reg.wdata[0];
              default: ;
            endcase
          end
          st_next.wst = WKG_W_RESP;
        end
      end
      WKG_W_RESP:
      begin
        if (s_axi_bready)
        begin
          st_next.wst = WKG_W_IDLE;
          st_next.aw_got = 1'b0;
          st_next.w_got = 1'b0;
        end
      end
      default: st_next.wst = WKG_W_IDLE;
    endcase
    case (st_reg.rst_s)
      WKG_R_IDLE:
      begin
        if (s_axi_arvalid)
        begin
          st_next.rst_s = WKG_R_RESP;
          st_next.rresp = wkg_hit(s_axi_araddr) ? `WKG_RESP_OKAY : `WKG_RESP_SLVERR;
          case (wkg_idx(s_axi_araddr))
            `WKG_IDX_EN3: st_next.rdata = {24'h000000, st_reg.en3};
            `WKG_IDX_EN4: st_next.rdata = {24'h000000, st_reg.en4};
            `WKG_IDX_STS3: st_next.rdata = {24'h000000, st_reg.sts3};
            `WKG_IDX_STS4: st_next.rdata = {24'h000000, st_reg.sts4};
            `WKG_IDX_MASTER: st_next.rdata = {31'h00000000, st_reg.wake_master_enable};
            default: st_next.rdata = 32'h00000000;
          endcase
          if (!wkg_hit(s_axi_araddr))
            st_next.rdata = 32'h00000000;
        end
      end
      WKG_R_RESP:
      begin
        if (s_axi_rready)
          st_next.rst_s = WKG_R_IDLE;
      end
      default: st_next.rst_s = WKG_R_IDLE;
    endcase
  end

  // --------------------------------
  // registers
  // --------------------------------
  // sys_rst leaves enables, status and master alone; only standby por clears them
  always_ff @(posedge mclk)
  begin
    if (standby_supply_power_on_reset)
    begin
      st_reg <= '0;
      st_reg.en3 <= `WKG_EN_RESET;
      st_reg.en4 <= `WKG_EN_RESET;
    end
    else if (sys_rst)
    begin
      st_reg <= st_next;
      st_reg.wst <= WKG_W_IDLE;
      st_reg.aw_got <= 1'b0;
      st_reg.w_got <= 1'b0;
      st_reg.rst_s <= WKG_R_IDLE;
      st_reg.en3 <= st_reg.en3;
      st_reg.en4 <= st_reg.en4;
    end
    else
      st_reg <= st_next;
  end

  // --------------------------------
  // outputs
  // --------------------------------
  wkg_gate u_gate (
    .en3(st_reg.en3),
    .en4(st_reg.en4),
    .sts3(st_reg.sts3),
    .sts4(st_reg.sts4),
    .master_en(st_reg.wake_master_enable),
    .wake_n(wake_n)
  );

  always_comb
  begin
    wake_request_out_n = wake_n;
    s_axi_awready = (st_reg.wst == WKG_W_IDLE) && !st_reg.aw_got;
    s_axi_wready = (st_reg.wst == WKG_W_IDLE) && !st_reg.w_got;
    s_axi_bvalid = (st_reg.wst == WKG_W_RESP);
    s_axi_bresp = st_reg.bresp;
    s_axi_arready = (st_reg.rst_s == WKG_R_IDLE);
    s_axi_rvalid = (st_reg.rst_s == WKG_R_RESP);
    s_axi_rdata = st_reg.rdata;
    s_axi_rresp = st_reg.rresp;
  end
endmodule : wkg_top

// >>> testbench/wkg_chk.sv
// handshake and reset assertions for wkg_top
// assumes bind by name onto the top module's ports
module wkg_chk(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic standby_supply_power_on_reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wake_request_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst || standby_supply_power_on_reset);
  por_clear_a: assert property (disable iff (1'b0) standby_supply_power_on_reset |=>
    wake_request_out_n && !s_axi_bvalid && !s_axi_rvalid) else $error("wake not idle after por");
  rst_idle_a: assert property (disable iff (1'b0) sys_rst |=> !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus not idle after reset");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while pending");
endmodule : wkg_chk
bind wkg_top wkg_chk u_chk(.*);

// >>> testbench/wkg_host_model.sv
// host side wake input: counts wake assertions
// assumes wake line is low active, sampled on mclk
module wkg_host_model(
  input wire logic mclk,
  input wire logic wake_request_out_n,
  output logic [7:0] wake_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b1;
  initial wake_count = 8'h00;
  always @(posedge mclk)
  begin
    if (last && !wake_request_out_n) wake_count <= wake_count + 8'h01;
    last <= wake_request_out_n;
  end
endmodule : wkg_host_model

// >>> testbench/tb_top.sv
// self-checking bench for wkg_top
// assumes wkg_params.svh on the include path
`include "wkg_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, sys_rst = 1, standby_supply_power_on_reset = 1;
  logic [15:0] ev = 16'h0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, wake_request_out_n;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
  logic [7:0] wake_count, c0;
  int failures = 0, checks_done = 0;
  wire gpin_20, gpin_21, gpin_22, grouped_irq, gpin_24, gpin_25, gpin_26, gpin_27;
  wire gpin_30, gpin_31, gpin_32, gpin_33, gpin_41, gpin_43, gpin_60, gpin_61;
  assign {gpin_61, gpin_60, gpin_43, gpin_41, gpin_33, gpin_32, gpin_31, gpin_30} = ev[15:8];
  assign {gpin_27, gpin_26, gpin_25, gpin_24, grouped_irq, gpin_22, gpin_21, gpin_20} = ev[7:0];
  wkg_top dut(.*);
  wkg_host_model host(.*);
  initial forever #25 mclk = ~mclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] i, input logic [7:0] v);
    @(posedge mclk);
    s_axi_awaddr <= {26'h0, i, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    b = s_axi_bresp;
    s_axi_bready <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] i);
    @(posedge mclk);
    s_axi_araddr <= {26'h0, i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd
  task automatic fire(input logic [15:0] v);
    @(posedge mclk) ev <= v;
    @(posedge mclk) ev <= 0;
    @(posedge mclk) #1;
  endtask : fire
  task automatic s_map;
    logic [15:0] m, s;
    c0 = wake_count;
    wr(`WKG_IDX_MASTER, 8'h01);
    for (int i = 0; i < 16; i++)
    begin
      m = 16'h1 << i;
      wr(`WKG_IDX_EN3, m[7:0]);
      wr(`WKG_IDX_EN4, m[15:8]);
      fire(m);
      chk("wake on", 0, wake_request_out_n);
      rd(`WKG_IDX_STS3);
      s[7:0] = d[7:0];
      rd(`WKG_IDX_STS4);
      s[15:8] = d[7:0];
      chk("status", m, s);
      wr(`WKG_IDX_STS3, m[7:0]);
      wr(`WKG_IDX_STS4, m[15:8]);
      chk("wake off", 1, wake_request_out_n);
    end
    chk("host wakes", c0 + 8'd16, wake_count);
  endtask : s_map
  task automatic s_gate;
    wr(`WKG_IDX_EN3, 8'hfe);
    wr(`WKG_IDX_EN4, 8'h00);
    fire(16'h1);
    chk("disabled wake", 1, wake_request_out_n);
    rd(`WKG_IDX_STS3);
    chk("disabled status", 1, d);
    wr(`WKG_IDX_STS3, 8'h01);
    wr(`WKG_IDX_MASTER, 8'h00);
    fire(16'h2);
    chk("master off", 1, wake_request_out_n);
    wr(`WKG_IDX_MASTER, 8'h01);
    chk("master on", 0, wake_request_out_n);
    wr(`WKG_IDX_STS3, 8'h02);
    chk("cleared", 1, wake_request_out_n);
  endtask : s_gate
  task automatic s_keep;
    wr(`WKG_IDX_EN3, 8'ha5);
    wr(`WKG_IDX_EN4, 8'h5a);
    chk("wr okay", `WKG_RESP_OKAY, b);
    // byte lane zero off: write answered okay but ignored
    @(posedge mclk) s_axi_wstrb <= 4'he;
    wr(`WKG_IDX_EN3, 8'h00);
    chk("masked okay", `WKG_RESP_OKAY, b);
    @(posedge mclk) s_axi_wstrb <= 4'hf;
    wr(4'hf, 8'hff);
    chk("wr unmapped", `WKG_RESP_SLVERR, b);
    @(posedge mclk) sys_rst <= 1;
    @(posedge mclk) sys_rst <= 0;
    rd(`WKG_IDX_EN3);
    chk("en3 kept", 32'ha5, d);
    rd(`WKG_IDX_EN4);
    chk("en4 kept", 32'h5a, d);
    @(posedge mclk) standby_supply_power_on_reset <= 1;
    @(posedge mclk) standby_supply_power_on_reset <= 0;
    rd(`WKG_IDX_EN3);
    chk("en3 por", `WKG_EN_RESET, d);
    rd(`WKG_IDX_EN4);
    chk("en4 por", `WKG_EN_RESET, d);
    rd(4'hf);
    chk("unmapped", `WKG_RESP_SLVERR, r);
  endtask : s_keep
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    #500us;
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 0;
    standby_supply_power_on_reset <= 0;
    #1 chk("wake idle", 1, wake_request_out_n);
    s_map();
    s_gate();
    s_keep();
    end_sim();
  end
endmodule : tb_top
